// [design/rbo_fab_host.sv]
// Fabric-side controller: triggers ordering, reads the FIFO, reports by registers
`timescale 1ns/100ps
`default_nettype none
module rbo_fab_host
  import rbo_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [31:0]       wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [31:0]       rdata_o,
  output logic                   irq_o,
  rbo_link_if.fab                link
);
  // ==========================================================================
  // Register decode
  // ==========================================================================
  logic [31:0]       ctrl_q;
  logic              trig_q;
  logic [DIV_W-1:0]  div_q;
  logic              rden_q;
  logic [WORD_W-1:0] data_q;
  logic              done_q;
  logic              done_seen_q;
  logic [IRQ_W-1:0]  irq_s_q;
  logic [IRQ_W-1:0]  irq_e_q;
  logic [IRQ_W-1:0]  irq_ev;
  logic [IRQ_W-1:0]  irq_clr;
  logic [31:0]       rdata_d;
  logic [31:0]       rdata_q;
  logic              irq_q;
  logic              wr_ctrl;
  logic              wr_trig;

  assign wr_ctrl = wr_i & (addr_i == OFS_CTRL);
  assign wr_trig = wr_ctrl & wdata_i[CTRL_TRIG_BIT];
  assign irq_clr = (wr_i && addr_i == OFS_IRQ_C) ? wdata_i[IRQ_W-1:0] : '0;
  assign irq_ev  = {link.fifo_err, link.order_done & ~done_seen_q, link.rd_valid};
  assign rdata_d = !rd_i ? 32'h0 :
                   (addr_i == OFS_CTRL)  ? {ctrl_q[31:2], 1'b0, ctrl_q[0]} :
                   (addr_i == OFS_STAT)  ? {30'h0, link.fifo_err, done_q} :
                   (addr_i == OFS_DATA)  ? {{(32 - WORD_W){1'b0}}, data_q} :
                   (addr_i == OFS_IRQ_S) ? {{(32 - IRQ_W){1'b0}}, irq_s_q} :
                   (addr_i == OFS_IRQ_E) ? {{(32 - IRQ_W){1'b0}}, irq_e_q} : 32'h0;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q  <= CTRL_RST;
      irq_e_q <= '0;
      irq_s_q <= '0;
      rdata_q <= '0;
      irq_q   <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl_q <= wdata_i;
      if (wr_i && addr_i == OFS_IRQ_E) irq_e_q <= wdata_i[IRQ_W-1:0];
      // Set wins over a clear in the same cycle
      irq_s_q <= (irq_s_q & ~irq_clr) | irq_ev;
      rdata_q <= rdata_d;
      irq_q   <= |(((irq_s_q & ~irq_clr) | irq_ev) & irq_e_q);
    end
  end

  // ==========================================================================
  // Ordering trigger and read clock enable
  // ==========================================================================
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      trig_q      <= 1'b0;
      div_q       <= '0;
      rden_q      <= 1'b0;
      data_q      <= '0;
      done_q      <= 1'b0;
      done_seen_q <= 1'b0;
    end else begin
      trig_q <= wr_trig;
      rden_q <= 1'b0;
      if (ctrl_q[CTRL_RDEN_BIT]) begin
        if (div_q == ctrl_q[CTRL_DIV_LSB +: DIV_W]) begin
          div_q  <= '0;
          rden_q <= 1'b1;
        end else begin
          div_q <= div_q + 1'b1;
        end
      end
      if (link.rd_valid) begin
        data_q      <= link.rd_data;
        done_q      <= link.order_done;
        done_seen_q <= link.order_done;
      end
    end
  end

  assign link.order_trig     = trig_q;
  assign link.rd_en          = rden_q;
  assign link.rd_clk_present = ctrl_q[CTRL_RDEN_BIT];
  assign rdata_o             = rdata_q;
  assign irq_o               = irq_q;
endmodule
`default_nettype wire

// [design/rbo_link_if.sv]
// Link between the receiver back end and the fabric-side controller
`timescale 1ns/100ps
`default_nettype none
interface rbo_link_if;
  import rbo_pkg::*;
  logic [WORD_W-1:0] rd_data;
  logic              rd_valid;
  logic              order_done;
  logic              fifo_err;
  logic              order_trig;
  logic              rd_en;
  logic              rd_clk_present;

  modport dev (output rd_data, rd_valid, order_done, fifo_err,
               input  order_trig, rd_en, rd_clk_present);
  modport fab (input  rd_data, rd_valid, order_done, fifo_err,
               output order_trig, rd_en, rd_clk_present);
endinterface
`default_nettype wire

// [design/rbo_pkg.sv]
// Shared constants and types for the byte ordering receiver and its fabric-side controller
package rbo_pkg;
  // ==========================================================================
  // Datapath
  // ==========================================================================
  localparam int unsigned LANE_W     = 9;
  localparam int unsigned WORD_W     = 2 * LANE_W;
  localparam int unsigned ENTRY_W    = WORD_W + 1;
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned LO_LSB     = 0;
  localparam int unsigned HI_LSB     = LANE_W;
  localparam int unsigned CTL_BIT    = 8;
  localparam int unsigned DONE_BIT   = WORD_W;
  // ==========================================================================
  // Phase compensation FIFO
  // ==========================================================================
  localparam int unsigned FIFO_LOW_DEPTH  = 4;
  localparam int unsigned FIFO_HIGH_DEPTH = 8;
  localparam int unsigned PTR_W           = 3;
  localparam int unsigned CNT_W           = 4;
  localparam logic [CNT_W-1:0] CNT_LOW    = 4'h4;
  localparam logic [CNT_W-1:0] CNT_HIGH   = 4'h8;
  localparam int unsigned LAT_LOW_MIN     = 2;
  localparam int unsigned LAT_LOW_MAX     = 3;
  localparam int unsigned LAT_HIGH_MIN    = 4;
  localparam int unsigned LAT_HIGH_MAX    = 5;
  // ==========================================================================
  // Write clock selection
  // ==========================================================================
  typedef enum logic [1:0] {
    RBO_WCLK_TX   = 2'h0,
    RBO_WCLK_RX   = 2'h1,
    RBO_WCLK_CORE = 2'h2
  } rbo_wclk_t;
  // ==========================================================================
  // Controller registers (byte addresses)
  // ==========================================================================
  localparam int unsigned ADDR_W          = 5;
  localparam logic [ADDR_W-1:0] OFS_CTRL  = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_STAT  = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_DATA  = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_S = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_E = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_C = 5'h14;
  localparam int unsigned CTRL_RDEN_BIT   = 0;
  localparam int unsigned CTRL_TRIG_BIT   = 1;
  localparam int unsigned CTRL_DIV_LSB    = 4;
  localparam int unsigned DIV_W           = 4;
  localparam int unsigned IRQ_W           = 3;
  localparam int unsigned IRQ_WORD        = 0;
  localparam int unsigned IRQ_DONE        = 1;
  localparam int unsigned IRQ_ERR         = 2;
  localparam logic [31:0] CTRL_RST        = 32'h0000_0000;
endpackage

// [design/rbo_rx_dev.sv]
// Receiver back end: byte ordering followed by the phase compensation FIFO
`timescale 1ns/100ps
`default_nettype none
module rbo_rx_dev
  import rbo_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic [WORD_W-1:0] lane_data_i,
  input  wire logic              tx_clk_en_i,
  input  wire logic              rx_clk_en_i,
  input  wire logic              core_clk_en_i,
  input  wire logic              bonded_i,
  input  wire logic              rate_match_i,
  input  wire logic              half_rate_i,
  input  wire logic              high_latency_i,
  input  wire logic              sync_status_i,
  input  wire logic              user_mode_i,
  input  wire logic              decoder_mode_i,
  input  wire logic [LANE_W-1:0] order_pattern_i,
  input  wire logic [LANE_W-1:0] fill_pattern_i,
  rbo_link_if.dev                link
);
  // ==========================================================================
  // Write clock selection and half-rate enables
  // ==========================================================================
  rbo_wclk_t wclk_sel;
  logic      wsrc_en;
  logic      rsrc_en;
  logic      wdiv_q;
  logic      rdiv_q;
  logic      wr_tick;
  logic      rd_tick;

  assign wclk_sel = bonded_i ? RBO_WCLK_CORE : (rate_match_i ? RBO_WCLK_TX : RBO_WCLK_RX);
  assign wsrc_en  = (wclk_sel == RBO_WCLK_CORE) ? core_clk_en_i :
                    (wclk_sel == RBO_WCLK_TX) ? tx_clk_en_i : rx_clk_en_i;
  assign rsrc_en  = link.rd_clk_present ? link.rd_en : wsrc_en;
  assign wr_tick  = wsrc_en & (~half_rate_i | wdiv_q);
  assign rd_tick  = rsrc_en & (~half_rate_i | rdiv_q);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wdiv_q <= 1'b0;
      rdiv_q <= 1'b0;
    end else begin
      if (wsrc_en) wdiv_q <= ~wdiv_q;
      if (rsrc_en) rdiv_q <= ~rdiv_q;
    end
  end

  // ==========================================================================
  // Trigger edge detection
  // ==========================================================================
  logic sync_q;
  logic trig_q;
  logic start;

  // Sync is high while lock is held and falls after the error count expires upstream
  assign start = user_mode_i ? (link.order_trig & ~trig_q)
                             : (sync_status_i & ~sync_q);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync_q <= 1'b0;
      trig_q <= 1'b0;
    end else begin
      sync_q <= sync_status_i;
      trig_q <= link.order_trig;
    end
  end

  // ==========================================================================
  // Byte ordering
  // ==========================================================================
  typedef enum logic [1:0] {
    RBO_ORD_IDLE,
    RBO_ORD_SEARCH,
    RBO_ORD_DONE
  } rbo_ord_t;

  rbo_ord_t          ord_q;
  rbo_ord_t          ord_d;
  logic              shift_q;
  logic              shift_d;
  logic              done_q;
  logic              done_d;
  logic              start_q;
  logic [LANE_W-1:0] held_q;
  logic [LANE_W-1:0] lo_lane;
  logic [LANE_W-1:0] hi_lane;
  logic [LANE_W-1:0] cmp_mask;
  logic              lo_hit;
  logic              hi_hit;
  logic [WORD_W-1:0] ord_word;

  assign lo_lane  = lane_data_i[LO_LSB +: LANE_W];
  assign hi_lane  = lane_data_i[HI_LSB +: LANE_W];
  // Without the decoder the control flag is not compared
  assign cmp_mask = decoder_mode_i ? {1'b1, {BYTE_W{1'b1}}} : {1'b0, {BYTE_W{1'b1}}};
  assign lo_hit   = ((lo_lane ^ order_pattern_i) & cmp_mask) == '0;
  assign hi_hit   = ((hi_lane ^ order_pattern_i) & cmp_mask) == '0;

  // A start seen between write ticks is remembered until the next tick
  always_comb begin
    ord_d   = ord_q;
    shift_d = shift_q;
    done_d  = done_q;
    if (start | start_q) begin
      if (wr_tick) begin
        ord_d  = RBO_ORD_SEARCH;
        done_d = 1'b0;
      end
    end else if (wr_tick && ord_q == RBO_ORD_SEARCH) begin
      if (lo_hit) begin
        ord_d   = RBO_ORD_DONE;
        shift_d = 1'b0;
        done_d  = 1'b1;
      end else if (hi_hit) begin
        ord_d   = RBO_ORD_DONE;
        shift_d = ~shift_q;
        done_d  = 1'b1;
      end
    end
  end

  // The pattern is expected in the lower lane of each transmitted word
  // Shifting inserts the fill byte and delays the upper byte one lane
  assign ord_word = (start | start_q) ? (shift_q ? {lo_lane, held_q} : lane_data_i) :
                    (ord_q == RBO_ORD_SEARCH && !lo_hit && hi_hit) ?
                      (shift_q ? lane_data_i : {lo_lane, fill_pattern_i}) :
                    (shift_q ? {lo_lane, held_q} : lane_data_i);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ord_q   <= RBO_ORD_IDLE;
      shift_q <= 1'b0;
      done_q  <= 1'b0;
      start_q <= 1'b0;
      held_q  <= '0;
    end else begin
      ord_q   <= ord_d;
      shift_q <= shift_d;
      done_q  <= done_d;
      start_q <= (start | start_q) & ~wr_tick;
      if (wr_tick) held_q <= hi_lane;
    end
  end

  // ==========================================================================
  // Phase compensation FIFO
  // ==========================================================================
  logic [ENTRY_W-1:0] mem_q [FIFO_HIGH_DEPTH];
  logic [PTR_W-1:0]   wptr_q;
  logic [PTR_W-1:0]   rptr_q;
  logic [CNT_W-1:0]   cnt_q;
  logic [CNT_W-1:0]   depth;
  logic [PTR_W-1:0]   wptr_nx;
  logic [PTR_W-1:0]   rptr_nx;
  logic               full;
  logic               empty;
  logic               do_wr;
  logic               do_rd;
  logic               err_ev;
  logic [WORD_W-1:0]  rd_data_q;
  logic               rd_valid_q;
  logic               order_done_q;
  logic               fifo_err_q;

  assign depth   = high_latency_i ? CNT_HIGH : CNT_LOW;
  assign full    = cnt_q == depth;
  assign empty   = cnt_q == '0;
  // A read in the same tick frees a slot, so a full FIFO still takes the word
  assign do_wr   = wr_tick & (~full | do_rd);
  assign do_rd   = rd_tick & ~empty;
  assign err_ev  = (wr_tick & full & ~rd_tick) | (rd_tick & empty);
  assign wptr_nx = (high_latency_i || wptr_q != PTR_W'(FIFO_LOW_DEPTH - 1)) ? wptr_q + 1'b1 : '0;
  assign rptr_nx = (high_latency_i || rptr_q != PTR_W'(FIFO_LOW_DEPTH - 1)) ? rptr_q + 1'b1 : '0;

  always_ff @(posedge clk_i) begin
    if (do_wr) mem_q[wptr_q] <= {done_d, ord_word};
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q  <= '0;
    end else begin
      if (do_wr) wptr_q <= wptr_nx;
      if (do_rd) rptr_q <= rptr_nx;
      cnt_q <= cnt_q + CNT_W'(do_wr) - CNT_W'(do_rd);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_q    <= '0;
      rd_valid_q   <= 1'b0;
      order_done_q <= 1'b0;
      fifo_err_q   <= 1'b0;
    end else begin
      rd_valid_q <= do_rd;
      fifo_err_q <= err_ev;
      if (do_rd) begin
        rd_data_q    <= mem_q[rptr_q][WORD_W-1:0];
        order_done_q <= mem_q[rptr_q][DONE_BIT];
      end
    end
  end

  assign link.rd_data    = rd_data_q;
  assign link.rd_valid   = rd_valid_q;
  assign link.order_done = order_done_q;
  assign link.fifo_err   = fifo_err_q;
endmodule
`default_nettype wire

// [testbench/rbo_assertions.sv]
// Concurrent checks on the link between the receiver back end and the fabric controller
`timescale 1ns/100ps
`default_nettype none
module rbo_assertions
  import rbo_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic [WORD_W-1:0] rd_data,
  input wire logic              rd_valid,
  input wire logic              order_done,
  input wire logic              fifo_err,
  input wire logic              order_trig,
  input wire logic              rd_en,
  input wire logic              rd_clk_present,
  input wire logic              half_rate
);
  // ====================
  // Link properties
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_data_holds: assert property (!rd_valid |-> $stable(rd_data)) else $error("rd_data moved");
  a_done_rise: assert property ($rose(order_done) |-> rd_valid) else $error("done rose alone");
  a_done_fall: assert property ($fell(order_done) |-> rd_valid) else $error("done fell alone");
  a_valid_cause: assert property (rd_valid |-> $past(rd_en) || !$past(rd_clk_present)) else $error("stray valid");
  a_read_answer: assert property (rd_en && rd_clk_present && !half_rate |=> rd_valid || fifo_err)
    else $error("no answer");
  a_half_answer: assert property ((half_rate && rd_en && rd_clk_present) ##1 (rd_en && rd_clk_present)
    |=> rd_valid || fifo_err || $past(rd_valid || fifo_err)) else $error("no half-rate answer");
  a_err_excl: assert property (!(rd_valid && fifo_err)) else $error("valid with error");
  a_trig_pulse: assert property (order_trig |=> !order_trig) else $error("trigger too long");
  a_rden_present: assert property (rd_en |-> rd_clk_present || $past(rd_clk_present)) else $error("read off");
endmodule
`default_nettype wire

// [testbench/testbench.sv]
// Self-checking bench for the receiver back end joined to the fabric controller
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import rbo_pkg::*;
  logic              clk_i, rst_i, wr_s, rd_s, sync, user, dec, bonded, rmatch, hlat, irq;
  logic              shf, srch, pend, done, sp, tp, edg, half, tk, wd;
  logic [2:0]        en;
  logic [WORD_W-1:0] lane, out;
  logic [LANE_W-1:0] pat, fill, lo, hi, hold;
  logic [ADDR_W-1:0] addr;
  logic [31:0]       wdata, rdata;
  logic [WORD_W:0]   e, lastw;
  logic [WORD_W:0]   exp_q[$];
  int                miscompares, n_tests, nerr, s, k, d, dep;
  rbo_link_if link ();
  rbo_rx_dev rbo_rx_dev_i (.clk_i(clk_i), .rst_i(rst_i), .lane_data_i(lane), .tx_clk_en_i(en[0]), .rx_clk_en_i(en[1]),
    .core_clk_en_i(en[2]), .bonded_i(bonded), .rate_match_i(rmatch), .half_rate_i(half), .high_latency_i(hlat),
    .sync_status_i(sync), .user_mode_i(user), .decoder_mode_i(dec), .order_pattern_i(pat), .fill_pattern_i(fill),
    .link(link));
  rbo_fab_host rbo_fab_host_i (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s),
    .rd_i(rd_s), .rdata_o(rdata), .irq_o(irq), .link(link));
  rbo_assertions rbo_assertions_i (.clk_i(clk_i), .rst_i(rst_i), .rd_data(link.rd_data), .rd_valid(link.rd_valid),
    .order_done(link.order_done), .fifo_err(link.fifo_err), .order_trig(link.order_trig), .rd_en(link.rd_en),
    .rd_clk_present(link.rd_clk_present), .half_rate(half));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // ====================
  // Reference model of ordering and the word stream
  function automatic logic mt(input logic [LANE_W-1:0] x);
    return dec ? x == pat : x[7:0] == pat[7:0];
  endfunction
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      exp_q.delete();
      {shf, srch, pend, done, sp, tp, wd} = '0;
    end else begin
      edg = user ? link.order_trig && !tp : sync && !sp;
      sp = sync;
      tp = link.order_trig;
      tk = en[bonded ? 2 : rmatch ? 0 : 1] && (!half || wd);
      if (en[bonded ? 2 : rmatch ? 0 : 1]) wd = !wd;
      if (tk) begin
        lo = lane[8:0];
        hi = lane[17:9];
        out = shf ? {lo, hold} : {hi, lo};
        if (edg || pend) {done, srch, pend} = 3'b010;
        else if (srch && mt(lo)) {done, srch, shf} = 3'b100;
        else if (srch && mt(hi)) begin
          {done, srch, shf} = 3'b101;
          out = {lo, fill};
        end
        hold = hi;
        exp_q.push_back({done, out});
      end else if (edg) pend = 1'b1;
    end
  end
  always @(posedge clk_i) if (!rst_i && link.rd_valid === 1'b1) begin
    e = exp_q.size() ? exp_q.pop_front() : 'x;
    lastw = {link.order_done, link.rd_data};
    check("rd_word", 32'(e), 32'(lastw));
  end
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) nerr <= 0;
    else if (link.fifo_err === 1'b1) nerr <= nerr + 1;
  end
  // ====================
  // Tasks
  task automatic check(input string n, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge clk_i);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] x);
    @(posedge clk_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_i);
    rd_s <= 1'b0;
    #1 check($sformatf("reg_%h", a), x, rdata);
  endtask
  task automatic send(input logic [WORD_W-1:0] w);
    @(posedge clk_i);
    lane <= w;
    en <= 3'($urandom) | 3'(1 << s);
    @(posedge clk_i);
    lane <= 18'($urandom);
    en <= 3'($urandom) & ~3'(1 << s);
  endtask
  function automatic logic [WORD_W-1:0] mk(input logic up);
    logic [LANE_W-1:0] p, r;
    p = dec ? pat : pat ^ 9'h100;
    r = 9'($urandom);
    return up ? {p, r} : {r, p};
  endfunction
  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    sync <= 1'b0;
    en <= 3'h0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask
  task automatic test_done();
    $display("miscompares=%0d n_tests=%0d", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #100us;
    miscompares++;
    test_done();
  end
  initial begin
    {rst_i, wr_s, rd_s, sync, user, dec, bonded, rmatch, hlat, half, en, lane, pat, fill, addr, wdata} = '0;
    rst_i = 1'b1;
    k = $urandom(67);
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    for (k = 0; k < 3; k++) begin
      if (k > 0) do_reset();
      s = k;
      bonded <= k == 2;
      rmatch <= k == 0;
      user <= k == 2;
      half <= k == 0;
      dec <= k != 2;
      pat <= 9'($urandom);
      fill <= 9'($urandom);
      wr(OFS_CTRL, 32'h1);
      repeat (3) send(18'($urandom));
      if (k == 2) wr(OFS_CTRL, 32'h3);
      else sync <= 1'b1;
      repeat (2) send(18'($urandom));
      send(mk(k == 2));
      repeat (3) send(18'($urandom));
      if (k == 1) begin
        sync <= 1'b0;
        send(18'($urandom));
        sync <= 1'b1;
        send(18'($urandom));
        send(mk(1'b1));
        repeat (3) send(18'($urandom));
      end
      repeat (6) @(posedge clk_i);
      wr(OFS_CTRL, 32'h0);
      repeat (4) @(posedge clk_i);
      wr(OFS_STAT, 32'hffff_ffff);
      rd(OFS_STAT, 32'h1);
      rd(OFS_DATA, 32'(e[WORD_W-1:0]));
      rd(5'h18, 32'h0);
      rd(OFS_IRQ_S, 32'h7);
      wr(OFS_IRQ_E, 32'h2);
      @(posedge clk_i);
      #1 check("irq_on", 32'h1, 32'(irq));
      wr(OFS_IRQ_C, 32'h7);
      @(posedge clk_i);
      #1 check("irq_off", 32'h0, 32'(irq));
    end
    for (d = 0; d < 2; d++) begin
      do_reset();
      hlat <= d[0];
      s = 1;
      bonded <= 1'b0;
      rmatch <= 1'b0;
      dep = d ? 8 : 4;
      wr(OFS_CTRL, 32'hf1);
      do @(posedge clk_i); while (link.rd_en !== 1'b1);
      repeat (dep + 1) begin
        en <= 3'h2;
        lane <= 18'($urandom);
        @(posedge clk_i);
      end
      en <= 3'h0;
      #1 check("err_full", 32'h1, 32'(nerr));
      @(posedge clk_i);
      @(posedge clk_i);
      #1 check("err_ovf", 32'h2, 32'(nerr));
    end
    test_done();
  end
endmodule
`default_nettype wire
